// ==== core/bei_pkg.sv ====
// package: shared constants and types for the bit error insert and sync block
package bei_pkg;

  // ****************************************************************
  // register map, byte addresses on the 32-bit bus
  // ****************************************************************
  localparam int         ADDR_W    = 4;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CMD  = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;
  localparam logic [3:0] ADDR_ECNT = 4'hc;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int          CMD_INSERT_BIT = 0;
  localparam int          STAT_LAMP_BIT  = 0;
  localparam int          STAT_RPT_BIT   = 1;
  localparam int          STAT_DATA_BIT  = 2;
  localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
  localparam logic [31:0] ECNT_RST       = 32'h0000_0000;

  // ****************************************************************
  // bus answers
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // pattern and rate constants
  // ****************************************************************
  localparam int         PRBS_STAGES = 7;
  localparam int         PRBS_TAP_A  = 6;
  localparam int         PRBS_TAP_B  = 7;
  localparam int         PRBS_LEN    = 127;
  localparam logic [6:0] PRBS_SEED   = 7'h7f;
  localparam logic [3:0] RATE_SEL_MAX = 4'ha;    // 1e-2 .. 1e-12, eleven settings
  localparam int         RATE_W      = 40;       // holds 10^12
  localparam logic [39:0] RATE_BASE  = 40'h00_0000_0064; // 100 bits at 1e-2

  // control register layout
  typedef struct packed {
    logic [19:0] rsvdHi;
    logic [3:0]  rateSel;   // decade index, 0 = 1e-2
    logic [3:0]  rsvdLo;
    logic        syncSrc;   // 0 generator data, 1 checker data
    logic        patPrbs;   // 0 alternating 0/1, 1 seven-stage pseudo-random
    logic        rptMode;   // 0 single, 1 repeat
    logic        errEna;    // insertion enable
  } bei_ctrl_t;

  // single insertion sequence
  typedef enum logic [1:0] {
    INS_IDLE,
    INS_ARMED,
    INS_SHOWN
  } bei_ins_st_t;

endpackage

// ==== core/bei_prbs_gen.sv ====
// seven-stage pseudo-random generator with a wrap pulse once per period
`timescale 1ns/1ns
module bei_prbs_gen
  import bei_pkg::*;
#(
  parameter int STAGES = PRBS_STAGES
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  output logic      prbsBit,
  output logic      prbsWrap
);

  logic [STAGES-1:0] lfsr_ff;
  logic [STAGES-1:0] nxt_lfsr;
  logic              feedBit;

  // feedback from stages six and seven
  assign feedBit = lfsr_ff[PRBS_TAP_A-1] ^ lfsr_ff[PRBS_TAP_B-1];

  // shift chain, one stage per bit
  for (genvar i = 0; i < STAGES; i++) begin : gStage
    if (i == 0) begin : gHead
      assign nxt_lfsr[i] = feedBit;
    end else begin : gBody
      assign nxt_lfsr[i] = lfsr_ff[i-1];
    end
  end

  // seed is all ones so the all-zero lock-up state is never entered
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lfsr_ff <= PRBS_SEED;
    end else begin
      lfsr_ff <= nxt_lfsr;
    end
  end

  assign prbsBit  = lfsr_ff[STAGES-1];
  assign prbsWrap = (lfsr_ff == PRBS_SEED);

endmodule

// ==== core/bei_rate_tick.sv ====
// decade rate divider: one tick every base times 10^sel bit cycles
`timescale 1ns/1ns
module bei_rate_tick
  import bei_pkg::*;
#(
  parameter logic [RATE_W-1:0] BASE = RATE_BASE
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [3:0] rateSel,
  output logic            tick
);

  logic [RATE_W-1:0] period;
  logic [RATE_W-1:0] cnt_ff;
  logic [RATE_W-1:0] nxt_cnt;
  logic              atEnd;

  // period = base * 10^sel; out-of-range selections clamp to the slowest
  function automatic logic [RATE_W-1:0] decadePeriod(input logic [3:0] sel);
    logic [RATE_W-1:0] p;
    logic [3:0]        s;
    p = BASE;
    s = (sel > RATE_SEL_MAX) ? RATE_SEL_MAX : sel;
    for (int k = 0; k < 10; k++) begin
      if (k < int'(s)) begin
        p = RATE_W'(p * RATE_W'(10));
      end
    end
    return p;
  endfunction

  assign period  = decadePeriod(rateSel);
  assign atEnd   = (cnt_ff >= period - RATE_W'(1));
  // counter restarts while stopped so the first error lands one full period in
  assign nxt_cnt = (!run || atEnd) ? '0 : cnt_ff + RATE_W'(1);
  assign tick    = run && atEnd;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule

// ==== core/bei_top.sv ====
// top: pattern source with bit error insertion, sync pulse and register slave
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
module bei_top
  import bei_pkg::*;
#(
  parameter logic [RATE_W-1:0] RATE_BASE_BITS = RATE_BASE
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi4-lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // serial path
  input  wire logic              chkPatStart,
  output logic                   dataOut,
  output logic                   syncOut,
  output logic                   insertLamp
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  bei_ctrl_t         ctrl_ff;
  logic [31:0]       ctrlWord;
  logic [31:0]       nxt_ctrlWord;
  logic [31:0]       errCnt_ff;
  logic [31:0]       nxt_errCnt;

  logic              awHeld_ff;
  logic [ADDR_W-1:0] awAddr_ff;
  logic              wHeld_ff;
  logic [31:0]       wData_ff;
  logic [3:0]        wStrb_ff;
  logic              bValid_ff;
  logic [1:0]        bResp_ff;
  logic              rValid_ff;
  logic [31:0]       rData_ff;
  logic [1:0]        rResp_ff;

  logic              awTake;
  logic              wTake;
  logic              wrDo;
  logic              wrCtrl;
  logic              wrCmd;
  logic              wrEcnt;
  logic              wrHit;
  logic              arTake;
  logic              rdHit;
  logic [31:0]       rdMux;
  logic [31:0]       statWord;

  bei_ins_st_t       insSt_ff;
  bei_ins_st_t       nxt_insSt;
  logic              insCmd;
  logic              singleFlip;
  logic              rptRun;
  logic              rptTick;
  logic              flipBit;

  logic              prbsBit;
  logic              prbsWrap;
  logic              altBit_ff;
  logic              patBit;
  logic              genWrap;
  logic              dataOut_ff;
  logic              syncOut_ff;

  // ****************************************************************
  // register bus slave
  // ****************************************************************

  // address and data are taken in either order and held until the write
  assign s_axi_awready = !awHeld_ff && !bValid_ff;
  assign s_axi_wready  = !wHeld_ff && !bValid_ff;
  assign awTake        = s_axi_awvalid && s_axi_awready;
  assign wTake         = s_axi_wvalid && s_axi_wready;
  assign wrDo          = awHeld_ff && wHeld_ff;

  // write decode
  assign wrCtrl = wrDo && (awAddr_ff == ADDR_CTRL);
  assign wrCmd  = wrDo && (awAddr_ff == ADDR_CMD);
  assign wrEcnt = wrDo && (awAddr_ff == ADDR_ECNT);
  assign wrHit  = (awAddr_ff == ADDR_CTRL) || (awAddr_ff == ADDR_CMD)
               || (awAddr_ff == ADDR_STAT) || (awAddr_ff == ADDR_ECNT);

  // byte lanes of the control word, one lane per strobe bit
  assign ctrlWord = ctrl_ff;
  for (genvar b = 0; b < 4; b++) begin : gLane
    assign nxt_ctrlWord[8*b +: 8] = (wrCtrl && wStrb_ff[b]) ? wData_ff[8*b +: 8]
                                                           : ctrlWord[8*b +: 8];
  end

  // write channel holding registers and response
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      awHeld_ff <= 1'b0;
      awAddr_ff <= '0;
      wHeld_ff  <= 1'b0;
      wData_ff  <= '0;
      wStrb_ff  <= '0;
      bValid_ff <= 1'b0;
      bResp_ff  <= RESP_OKAY;
    end else begin
      if (awTake) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end else if (wrDo) begin
        awHeld_ff <= 1'b0;
      end
      if (wTake) begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end else if (wrDo) begin
        wHeld_ff <= 1'b0;
      end
      if (wrDo) begin
        bValid_ff <= 1'b1;
        bResp_ff  <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bValid_ff <= 1'b0;
      end
    end
  end

  // control register; reserved fields are forced back to zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_ff <= CTRL_RST;
    end else begin
      ctrl_ff        <= nxt_ctrlWord;
      ctrl_ff.rsvdHi <= '0;
      ctrl_ff.rsvdLo <= '0;
    end
  end

  // read path: one request at a time, data from a register
  assign s_axi_arready = !rValid_ff;
  assign arTake        = s_axi_arvalid && s_axi_arready;
  assign statWord      = {29'h0, dataOut_ff, rptRun, insertLamp};
  assign rdHit         = (s_axi_araddr == ADDR_CTRL) || (s_axi_araddr == ADDR_CMD)
                      || (s_axi_araddr == ADDR_STAT) || (s_axi_araddr == ADDR_ECNT);
  assign rdMux = (s_axi_araddr == ADDR_CTRL) ? ctrlWord :
                 (s_axi_araddr == ADDR_STAT) ? statWord :
                 (s_axi_araddr == ADDR_ECNT) ? errCnt_ff : 32'h0000_0000;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rValid_ff <= 1'b0;
      rData_ff  <= '0;
      rResp_ff  <= RESP_OKAY;
    end else if (arTake) begin
      rValid_ff <= 1'b1;
      rData_ff  <= rdMux;
      rResp_ff  <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rValid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bValid_ff;
  assign s_axi_bresp  = bResp_ff;
  assign s_axi_rvalid = rValid_ff;
  assign s_axi_rdata  = rData_ff;
  assign s_axi_rresp  = rResp_ff;

  // ****************************************************************
  // pattern sources
  // ****************************************************************
  bei_prbs_gen #(
    .STAGES (PRBS_STAGES)
  ) uPrbs (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .prbsBit  (prbsBit),
    .prbsWrap (prbsWrap)
  );

  // alternating source free-runs so a later switch has no phase jump
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      altBit_ff <= 1'b0;
    end else begin
      altBit_ff <= !altBit_ff;
    end
  end

  // pattern select and its repetition marker
  assign patBit  = ctrl_ff.patPrbs ? prbsBit : altBit_ff;
  assign genWrap = ctrl_ff.patPrbs ? prbsWrap : !altBit_ff;

  // ****************************************************************
  // error insertion
  // ****************************************************************

  // single command only counts with enable on and single mode chosen
  assign insCmd = wrCmd && wStrb_ff[0] && wData_ff[CMD_INSERT_BIT]
               && ctrl_ff.errEna && !ctrl_ff.rptMode;

  // armed: flip this bit; shown: lamp holds one more cycle.
  // a command landing in the flip cycle re-arms, so it is never lost
  always_comb begin
    nxt_insSt = insSt_ff;
    case (insSt_ff)
      INS_IDLE: begin
        if (insCmd) begin
          nxt_insSt = INS_ARMED;
        end
      end
      INS_ARMED: begin
        nxt_insSt = insCmd ? INS_ARMED : INS_SHOWN;
      end
      INS_SHOWN: begin
        nxt_insSt = insCmd ? INS_ARMED : INS_IDLE;
      end
      default: begin
        nxt_insSt = INS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      insSt_ff <= INS_IDLE;
    end else begin
      insSt_ff <= nxt_insSt;
    end
  end

  assign singleFlip = (insSt_ff == INS_ARMED);
  assign insertLamp = (insSt_ff != INS_IDLE);

  // repeat mode stops the very cycle enable drops
  assign rptRun = ctrl_ff.errEna && ctrl_ff.rptMode;

  bei_rate_tick #(
    .BASE (RATE_BASE_BITS)
  ) uRate (
    .clk_sys (clk_sys),
    .rst     (rst),
    .run     (rptRun),
    .rateSel (ctrl_ff.rateSel),
    .tick    (rptTick)
  );

  assign flipBit = singleFlip || (rptRun && rptTick);

  // error counter, software may reload it; a flip wins over the write
  assign nxt_errCnt = flipBit ? errCnt_ff + 32'h1
                    : (wrEcnt ? wData_ff : errCnt_ff);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      errCnt_ff <= ECNT_RST;
    end else begin
      errCnt_ff <= nxt_errCnt;
    end
  end

  // ****************************************************************
  // serial outputs
  // ****************************************************************

  // data and sync share one register stage so they stay aligned
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dataOut_ff <= 1'b0;
      syncOut_ff <= 1'b0;
    end else begin
      dataOut_ff <= patBit ^ flipBit;
      syncOut_ff <= ctrl_ff.syncSrc ? chkPatStart : genWrap;
    end
  end

  assign dataOut = dataOut_ff;
  assign syncOut = syncOut_ff;

endmodule

// ==== sim/bei_top_asserts.sv ====
// checker: bus handshake, insertion lamp and sync properties of the top
`timescale 1ns/1ns
module bei_chk
  import bei_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        chkPatStart,
  input wire logic        syncOut,
  input wire logic        insertLamp
);
  // ****************************************************************
  // properties, one clock domain
  // ****************************************************************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // both write channels taken at one edge
  sequence s_wTake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_lampOn;
    $rose(insertLamp);
  endsequence

  // the held pair acts one cycle after the take, the answer shows the cycle after that
  property p_bAns; s_wTake |-> ##2 s_axi_bvalid; endproperty
  property p_bHold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  property p_bBlk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  property p_rAns; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_rHold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  property p_rBlk; s_axi_rvalid |-> !s_axi_arready; endproperty
  // lamp only ever follows an accepted command write
  property p_lampCause; s_lampOn |-> s_axi_bvalid || $past(s_axi_bvalid); endproperty
  property p_lampTwo; s_lampOn |=> insertLamp; endproperty
  // back-to-back sync pulses can only come from the checker input
  property p_syncPair; syncOut && $past(syncOut) |-> $past(chkPatStart) || $past(chkPatStart, 2); endproperty

  a_bAns: assert property (p_bAns) else $error("write answer missing");
  a_bHold: assert property (p_bHold) else $error("write answer dropped early");
  a_bBlk: assert property (p_bBlk) else $error("write accepted while answer pending");
  a_rAns: assert property (p_rAns) else $error("read answer missing");
  a_rHold: assert property (p_rHold) else $error("read answer dropped early");
  a_rBlk: assert property (p_rBlk) else $error("read accepted while answer pending");
  a_lampCause: assert property (p_lampCause) else $error("lamp without command");
  a_lampTwo: assert property (p_lampTwo) else $error("lamp too short");
  a_syncPair: assert property (p_syncPair) else $error("sync pulse too wide");
endmodule

bind bei_top bei_chk bei_chk_inst (.clk_sys(clk_sys), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .chkPatStart(chkPatStart),
  .syncOut(syncOut), .insertLamp(insertLamp));

// ==== sim/bei_ed_model.sv ====
// partner: error checker that makes pattern-start pulses and triggers on sync
`timescale 1ns/1ns
module bei_errchk_model (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic syncOut,
  output logic      chkPatStart
);
  logic [2:0] cnt_ff;
  int         nTrig;
  // two pulses back to back every eight bits, the awkward case for a copier
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_ff      <= 3'h0;
      chkPatStart <= 1'b0;
    end else begin
      cnt_ff      <= cnt_ff + 3'h1;
      chkPatStart <= (cnt_ff < 3'h2);
    end
  end
  // trigger taken from the sync output
  always_ff @(posedge clk_sys) begin
    if (syncOut) nTrig <= nTrig + 1;
  end
endmodule

// ==== sim/tb_top.sv ====
// testbench: register, pattern, insertion and sync scenarios
`timescale 1ns/1ns
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  import bei_pkg::*;
  localparam logic [39:0] BASE = 40'h4; // short rate base keeps runs brief
  logic        clk_sys, rst, awvalid, awready, wvalid, wready, bvalid, bready, prevD, glF;
  logic        arvalid, arready, rvalid, rready, chkPatStart, dataOut, syncOut, insertLamp;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [1:0]  bresp, rresp, rs;
  int          n_fail, compares, cyc, nErr, nLamp, lastErr, lastGap;

  bei_top #(.RATE_BASE_BITS(BASE)) bei_top_inst (.clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .chkPatStart(chkPatStart), .dataOut(dataOut), .syncOut(syncOut), .insertLamp(insertLamp));
  bei_errchk_model bei_errchk_model_inst (.clk_sys(clk_sys), .rst(rst), .syncOut(syncOut),
    .chkPatStart(chkPatStart));

  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end

  // error starts seen as a break in the alternating stream
  always @(posedge clk_sys) begin
    prevD <= dataOut;
    glF <= (dataOut === prevD);
    if ((dataOut === prevD) && !glF) begin
      nErr++;
      lastGap = cyc - lastErr;
      lastErr = cyc;
    end
    if (insertLamp) nLamp++;
    cyc++;
  end

  // lag keeps the answer's ready low for that many edges, so a stalled answer is seen;
  // only the watchdog ends a wait that never gets its answer
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r, input int lag = 0);
    logic ta = 0, tw = 0, tb = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= (lag == 0);
    while (!tb) begin
      @(negedge clk_sys);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      r = bresp;
      @(posedge clk_sys);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      if (lag > 0) begin
        lag--;
        if (lag == 0) bready <= 1;
      end
    end
    bready <= 0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r, input int lag = 0);
    logic ta = 0, tr = 0;
    araddr <= a;
    arvalid <= 1;
    rready <= (lag == 0);
    while (!tr) begin
      @(negedge clk_sys);
      ta = arvalid && arready;
      tr = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge clk_sys);
      if (ta) arvalid <= 0;
      if (lag > 0) begin
        lag--;
        if (lag == 0) rready <= 1;
      end
    end
    rready <= 0;
    @(posedge clk_sys);
  endtask

  // counters cleared away from the sampling edge
  task automatic clr;
    @(negedge clk_sys);
    nErr = 0;
    nLamp = 0;
    @(posedge clk_sys);
  endtask

  task automatic t_regs;
    rd(ADDR_CTRL, rv, rs);
    `CHK(rv, CTRL_RST)
    rd(ADDR_ECNT, rv, rs);
    `CHK(rv, ECNT_RST)
    wr(ADDR_CTRL, 32'hffff_ffff, rs);
    rd(ADDR_CTRL, rv, rs, 3);
    `CHK(rv, 32'h0000_0f0f)
    rd(ADDR_STAT, rv, rs);
    `CHK({rv[31:3], rv[1:0]}, 31'h2)
    wr(4'h2, 32'h1, rs);
    `CHK(rs, RESP_SLVERR)
    rd(4'h2, rv, rs);
    `CHK({rv, rs}, {32'h0, RESP_SLVERR})
    wr(ADDR_CTRL, 32'h0, rs, 3);
    `CHK(rs, RESP_OKAY)
  endtask

  task automatic t_alt;
    int k = 0;
    clr;
    repeat (20) begin
      @(negedge clk_sys);
      k += syncOut + (syncOut && dataOut) * 100;
    end
    `CHK(nErr, 0)
    `CHK(k, 10)
    @(posedge clk_sys);
  endtask

  task automatic t_prbs;
    logic b[254];
    int k = 0, s = 0, e = 0, o = 0;
    int n0;
    wr(ADDR_CTRL, 32'h4, rs);
    do begin
      @(negedge clk_sys);
      k++;
    end while (!syncOut && k < 300);
    n0 = bei_errchk_model_inst.nTrig;
    for (int i = 0; i < 254; i++) begin
      b[i] = dataOut;
      s += syncOut * i;
      o += dataOut;
      if (i > 6 && b[i] !== (b[i-6] ^ b[i-7])) e++;
      @(negedge clk_sys);
    end
    `CHK(e, 0)
    `CHK(o, 128)
    `CHK(s, 127)
    `CHK(bei_errchk_model_inst.nTrig - n0, 2)
    @(posedge clk_sys);
  endtask

  task automatic t_chk;
    logic p;
    int e = 0, s = 0;
    wr(ADDR_CTRL, 32'h8, rs);
    @(negedge clk_sys);
    p = chkPatStart;
    repeat (40) begin
      @(negedge clk_sys);
      if (syncOut !== p) e++;
      s += syncOut;
      p = chkPatStart;
    end
    `CHK(e, 0)
    `CHK(s, 10)
    @(posedge clk_sys);
  endtask

  task automatic t_single;
    wr(ADDR_CTRL, 32'h0, rs);
    clr;
    wr(ADDR_CMD, 32'h1, rs);
    repeat (8) @(posedge clk_sys);
    `CHK(nErr, 0)
    wr(ADDR_CTRL, 32'h1, rs);
    clr;
    wr(ADDR_CMD, 32'h1, rs);
    repeat (8) @(posedge clk_sys);
    `CHK(nErr, 1)
    `CHK(nLamp, 2)
    rd(ADDR_ECNT, rv, rs);
    `CHK(rv, 32'h1)
  endtask

  task automatic t_rpt;
    int p;
    for (int sl = 0; sl < 3; sl++) begin
      p = 4 * (10 ** sl);
      wr(ADDR_ECNT, 32'h0, rs);
      clr;
      wr(ADDR_CTRL, 32'h3 | (32'(sl) << 8), rs);
      // the start write returns two edges after it acts, the stop write acts two edges after its call: end half a period past the tenth error
      repeat (10 * p + p / 2 - 4) @(posedge clk_sys);
      wr(ADDR_CTRL, 32'h2, rs);
      `CHK(lastGap, p)
      rd(ADDR_ECNT, rv, rs);
      `CHK(rv, 32'd10)
      clr;
      repeat (3 * p) @(posedge clk_sys);
      `CHK(nErr, 0)
    end
  endtask

  task automatic results;
    $display("fails=%0d compares=%0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #200000;
    n_fail++;
    results;
  end

  initial begin
    rst = 1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata} = 40'h0;
    repeat (3) @(posedge clk_sys);
    rst <= 0;
    @(posedge clk_sys);
    t_regs;
    t_alt;
    t_prbs;
    t_chk;
    t_single;
    t_rpt;
    results;
  end
endmodule
